/* hdl/clock_buffer_pkg.sv */
// Constants, field layouts and types of the clock buffer SMBus register bank
// Summary of operation
// - Answer write address D0 plus twice the strap code, D0 through DE.
// - Strap bit 2 high gives zero-delay PLL mode, low gives PLL bypass fanout.
// - Block write: address, index and count each acknowledged by the device.
// - Count data bytes stored at consecutive indices, each acknowledged, stop ends.
// - Block read: address, index, repeated start, read address acknowledged.
// - Read returns byte count first, then registers from index onward.
// - Readback count register is sent as the first read byte; resets with bits 3 and 0 set.
// - Register 0 bits 7 and 6 pick gear or 1:1 per group, reset 1.
// - Register 0 bits 4:0 gear code; bit 4 latched from frequency pin.
// - One enable bit per output pair in registers 1 and 2, reset 1.
// - Register 2 bit 6 bandwidth; a 0 from bit or pin selects high.
// - Register 2 bit 5 PLL select; a 0 from bit or strap forces bypass.
// - Registers 3 and 4 read back present pin levels; 4 bits 4:3 zero.
// - Register 5 holds revision and vendor identity, writes have no effect.
// - Register 8 bits 2:0 one-to-one code, bit 0 latched, upper bits zero.
// - Register 10 bit 7 enables direct divider programming, reset 0.
// - Gear M divider in register 11 bits 5:0, N divider in register 12.
// - Active-low enable pin at 1 floats its pair, at 0 lets it drive.
package clock_buffer_pkg;
	localparam int REG_COUNT = 13;
	localparam logic [7:0] IDX_GEAR = 8'h00;
	localparam logic [7:0] IDX_OE_LOW = 8'h01;
	localparam logic [7:0] IDX_OE_BW = 8'h02;
	localparam logic [7:0] IDX_PIN_LOW = 8'h03;
	localparam logic [7:0] IDX_PIN_HIGH = 8'h04;
	localparam logic [7:0] IDX_IDENT = 8'h05;
	localparam logic [7:0] IDX_DEVICE = 8'h06;
	localparam logic [7:0] IDX_COUNT = 8'h07;
	localparam logic [7:0] IDX_FREQ = 8'h08;
	localparam logic [7:0] IDX_MN_EN = 8'h0a;
	localparam logic [7:0] IDX_GEAR_M = 8'h0b;
	localparam logic [7:0] IDX_GEAR_N = 8'h0c;
	localparam logic [7:0] IDX_LAST = 8'h0c;
	// Seven-bit form of write address d0
	localparam logic [6:0] ADDR_BASE = 7'h68;
	localparam int GEAR10_BIT = 7;
	localparam int GEAR2_BIT = 6;
	localparam int GEAR_LATCH_BIT = 4;
	localparam int BW_BIT = 6;
	localparam int PLL_BIT = 5;
	localparam int FREQ_LATCH_BIT = 0;
	localparam int MN_EN_BIT = 7;
	localparam logic [7:0] COUNT_RESET = 8'h09;
	// Index 12 down to 0
	localparam logic [12:0][7:0] REG_RESET = {8'h00, 8'h00, 8'h00, 8'h00, 8'h02,
		COUNT_RESET, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'heb};
	localparam logic [12:0][7:0] REG_WMASK = {8'hff, 8'h3f, 8'h80, 8'h00, 8'h07,
		8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h6f, 8'hff, 8'hff};
	localparam logic [12:0][7:0] REG_ONES = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h90, 8'h00, 8'h00};

	typedef struct packed {
		logic frequency_select_pin;
		logic bandwidth_select_pin;
		logic [2:0] slave_address_strap;
		logic upper_pair_enable_pin_n;
		logic [9:0] output_enable_pin_n;
	} pin_in_t;

	typedef struct packed {
		logic zero_delay_mode;
		logic high_bandwidth;
		logic group10_one_to_one;
		logic group2_one_to_one;
		logic [4:0] gear_ratio_code;
		logic [2:0] one_to_one_frequency_code;
		logic divider_program_enable;
		logic [5:0] gear_m_divider;
		logic [7:0] gear_n_divider;
	} pll_control_t;

	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_CMD, ST_COUNT, ST_WDATA, ST_TX, ST_IGNORE
	} bus_state_t;
endpackage

/* hdl/clock_buffer_smbus_regs.sv */
// SMBus slave and control register bank of the differential clock buffer
`timescale 1ns/100ps
`default_nettype none
module clock_buffer_smbus_regs #(
	// Arbitrary identity values
	parameter logic [3:0] REVISION_ID = 4'h2,
	parameter logic [3:0] VENDOR_ID = 4'h6,
	parameter logic [7:0] DEVICE_ID = 8'h5a
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// SMBus pins
	input wire logic smb_clk,
	input wire logic smb_data_in,
	output logic smb_data_out,
	output logic smb_data_oe_n,
	// Strap, select and enable pins
	input wire clock_buffer_pkg::pin_in_t pins,
	// Control toward PLLs and output drivers
	output clock_buffer_pkg::pll_control_t pll_control,
	output logic [11:0] clock_output_pair_enable
);

	////////////////////////////////////////////////////////////////////////////
	// Synchronisers and bus events
	logic scl_s1_reg, scl_s2_reg, scl_d_reg;
	logic sda_s1_reg, sda_s2_reg, sda_d_reg;
	clock_buffer_pkg::pin_in_t pins_s1_reg, pins_s2_reg;

	always_ff @(posedge clk) begin
		scl_s1_reg <= smb_clk;
		scl_s2_reg <= scl_s1_reg;
		scl_d_reg <= scl_s2_reg;
		sda_s1_reg <= smb_data_in;
		sda_s2_reg <= sda_s1_reg;
		sda_d_reg <= sda_s2_reg;
		pins_s1_reg <= pins;
		pins_s2_reg <= pins_s1_reg;
	end

	logic scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_rise = scl_s2_reg & ~scl_d_reg;
	assign scl_fall = ~scl_s2_reg & scl_d_reg;
	assign bus_start = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
	assign bus_stop = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

	////////////////////////////////////////////////////////////////////////////
	// Register storage and read mux
	logic [7:0] regs_reg [clock_buffer_pkg::REG_COUNT];
	logic [7:0] regs_next [clock_buffer_pkg::REG_COUNT];
	logic latch_pending_reg;
	logic wr_en;
	logic [3:0] wr_idx;
	logic [7:0] wr_data;

	function automatic logic [7:0] read_byte(input logic [7:0] idx);
		logic [3:0] i;
		i = idx[3:0];
		case (idx)
			clock_buffer_pkg::IDX_PIN_LOW: read_byte = pins_s2_reg.output_enable_pin_n[7:0];
			clock_buffer_pkg::IDX_PIN_HIGH: read_byte = {pins_s2_reg.frequency_select_pin,
				pins_s2_reg.bandwidth_select_pin, pins_s2_reg.slave_address_strap[2], 2'b00,
				pins_s2_reg.upper_pair_enable_pin_n, pins_s2_reg.output_enable_pin_n[9:8]};
			clock_buffer_pkg::IDX_IDENT: read_byte = {REVISION_ID, VENDOR_ID};
			default: begin
				if (idx <= clock_buffer_pkg::IDX_LAST) begin
					read_byte = (regs_reg[i] & clock_buffer_pkg::REG_WMASK[i])
						| clock_buffer_pkg::REG_ONES[i];
				end else begin
					read_byte = 8'h00;
				end
			end
		endcase
	endfunction

	always_comb begin
		regs_next = regs_reg;
		if (latch_pending_reg) begin
			regs_next[clock_buffer_pkg::IDX_GEAR[3:0]][clock_buffer_pkg::GEAR_LATCH_BIT] =
				pins_s2_reg.frequency_select_pin;
			regs_next[clock_buffer_pkg::IDX_FREQ[3:0]][clock_buffer_pkg::FREQ_LATCH_BIT] =
				pins_s2_reg.frequency_select_pin;
		end
		// Read-only and reserved bits keep their stored value
		if (wr_en) begin
			regs_next[wr_idx] = (wr_data & clock_buffer_pkg::REG_WMASK[wr_idx])
				| (regs_reg[wr_idx] & ~clock_buffer_pkg::REG_WMASK[wr_idx]);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			for (int k = 0; k < clock_buffer_pkg::REG_COUNT; k++) begin
				regs_reg[k] <= clock_buffer_pkg::REG_RESET[k];
			end
			regs_reg[clock_buffer_pkg::IDX_DEVICE[3:0]] <= DEVICE_ID;
			latch_pending_reg <= 1'b1;
		end else begin
			regs_reg <= regs_next;
			latch_pending_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// SMBus slave state machine
	clock_buffer_pkg::bus_state_t state_reg, state_next;
	logic [3:0] bitcnt_reg, bitcnt_next;
	logic [7:0] shift_reg, shift_next;
	logic [7:0] tx_reg, tx_next;
	logic [7:0] ptr_reg, ptr_next;
	logic [7:0] remain_reg, remain_next;
	logic ack_reg, ack_next;
	logic sda_oe_n_reg, sda_oe_n_next;
	logic [6:0] own_addr;
	logic byte_done;

	assign own_addr = clock_buffer_pkg::ADDR_BASE
		+ 7'(pins_s2_reg.slave_address_strap);
	assign byte_done = scl_fall && !ack_reg && bitcnt_reg == 4'h8;

	always_comb begin
		state_next = state_reg;
		bitcnt_next = bitcnt_reg;
		shift_next = shift_reg;
		tx_next = tx_reg;
		ptr_next = ptr_reg;
		remain_next = remain_reg;
		ack_next = ack_reg;
		sda_oe_n_next = sda_oe_n_reg;
		wr_en = 1'b0;
		wr_idx = ptr_reg[3:0];
		wr_data = shift_reg;
		if (bus_stop) begin
			state_next = clock_buffer_pkg::ST_IDLE;
			ack_next = 1'b0;
			sda_oe_n_next = 1'b1;
		end else if (bus_start) begin
			state_next = clock_buffer_pkg::ST_ADDR;
			bitcnt_next = 4'h0;
			ack_next = 1'b0;
			sda_oe_n_next = 1'b1;
		end else if (ack_reg) begin
			// End of device ack slot; a read starts driving bit 7 here
			if (scl_fall) begin
				ack_next = 1'b0;
				bitcnt_next = 4'h0;
				sda_oe_n_next = (state_reg == clock_buffer_pkg::ST_TX) ? tx_reg[7] : 1'b1;
			end
		end else if (state_reg == clock_buffer_pkg::ST_TX) begin
			if (scl_rise) begin
				if (bitcnt_reg == 4'h8) begin
					if (sda_s2_reg) begin
						state_next = clock_buffer_pkg::ST_IGNORE;
					end else begin
						tx_next = read_byte(ptr_reg);
						ptr_next = ptr_reg + 8'h01;
						bitcnt_next = 4'h0;
					end
				end else begin
					bitcnt_next = bitcnt_reg + 4'h1;
				end
			end else if (scl_fall) begin
				sda_oe_n_next = (bitcnt_reg == 4'h8) | tx_reg[3'd7 - bitcnt_reg[2:0]];
			end
		end else if (state_reg != clock_buffer_pkg::ST_IDLE
			&& state_reg != clock_buffer_pkg::ST_IGNORE) begin
			if (scl_rise && bitcnt_reg != 4'h8) begin
				shift_next = {shift_reg[6:0], sda_s2_reg};
				bitcnt_next = bitcnt_reg + 4'h1;
			end else if (byte_done) begin
				ack_next = 1'b1;
				sda_oe_n_next = 1'b0;
				case (state_reg)
					clock_buffer_pkg::ST_ADDR: begin
						if (shift_reg[7:1] != own_addr) begin
							ack_next = 1'b0;
							sda_oe_n_next = 1'b1;
							state_next = clock_buffer_pkg::ST_IGNORE;
						end else if (shift_reg[0]) begin
							state_next = clock_buffer_pkg::ST_TX;
							tx_next = read_byte(clock_buffer_pkg::IDX_COUNT);
						end else begin
							state_next = clock_buffer_pkg::ST_CMD;
						end
					end
					clock_buffer_pkg::ST_CMD: begin
						ptr_next = shift_reg;
						state_next = clock_buffer_pkg::ST_COUNT;
					end
					clock_buffer_pkg::ST_COUNT: begin
						remain_next = shift_reg;
						state_next = clock_buffer_pkg::ST_WDATA;
					end
					clock_buffer_pkg::ST_WDATA: begin
						// Bytes past the count are acked and dropped
						if (remain_reg != 8'h00) begin
							wr_en = ptr_reg <= clock_buffer_pkg::IDX_LAST;
							remain_next = remain_reg - 8'h01;
							ptr_next = ptr_reg + 8'h01;
						end
					end
					default: begin
						state_next = clock_buffer_pkg::ST_IGNORE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= clock_buffer_pkg::ST_IDLE;
			bitcnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			ptr_reg <= 8'h00;
			remain_reg <= 8'h00;
			ack_reg <= 1'b0;
			sda_oe_n_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			bitcnt_reg <= bitcnt_next;
			shift_reg <= shift_next;
			tx_reg <= tx_next;
			ptr_reg <= ptr_next;
			remain_reg <= remain_next;
			ack_reg <= ack_next;
			sda_oe_n_reg <= sda_oe_n_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control outputs
	clock_buffer_pkg::pll_control_t ctrl_reg, ctrl_next;
	logic [11:0] drive_reg, drive_next;
	logic [11:0] enable_bits;
	logic sda_out_reg;

	assign enable_bits = {regs_reg[clock_buffer_pkg::IDX_OE_BW[3:0]][3:0],
		regs_reg[clock_buffer_pkg::IDX_OE_LOW[3:0]]};

	for (genvar g = 0; g < 12; g++) begin : g_pair
		if (g < 10) begin : g_single
			assign drive_next[g] = enable_bits[g]
				& ~pins_s2_reg.output_enable_pin_n[g];
		end else begin : g_upper
			assign drive_next[g] = enable_bits[g]
				& ~pins_s2_reg.upper_pair_enable_pin_n;
		end
	end

	always_comb begin
		ctrl_next.zero_delay_mode = pins_s2_reg.slave_address_strap[2]
			& regs_reg[clock_buffer_pkg::IDX_OE_BW[3:0]][clock_buffer_pkg::PLL_BIT];
		ctrl_next.high_bandwidth = ~(pins_s2_reg.bandwidth_select_pin
			& regs_reg[clock_buffer_pkg::IDX_OE_BW[3:0]][clock_buffer_pkg::BW_BIT]);
		ctrl_next.group10_one_to_one =
			regs_reg[clock_buffer_pkg::IDX_GEAR[3:0]][clock_buffer_pkg::GEAR10_BIT];
		ctrl_next.group2_one_to_one =
			regs_reg[clock_buffer_pkg::IDX_GEAR[3:0]][clock_buffer_pkg::GEAR2_BIT];
		ctrl_next.gear_ratio_code = regs_reg[clock_buffer_pkg::IDX_GEAR[3:0]][4:0];
		ctrl_next.one_to_one_frequency_code =
			regs_reg[clock_buffer_pkg::IDX_FREQ[3:0]][2:0];
		ctrl_next.divider_program_enable =
			regs_reg[clock_buffer_pkg::IDX_MN_EN[3:0]][clock_buffer_pkg::MN_EN_BIT];
		ctrl_next.gear_m_divider = regs_reg[clock_buffer_pkg::IDX_GEAR_M[3:0]][5:0];
		ctrl_next.gear_n_divider = regs_reg[clock_buffer_pkg::IDX_GEAR_N[3:0]];
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_reg <= '0;
			drive_reg <= 12'h000;
			sda_out_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			drive_reg <= drive_next;
			sda_out_reg <= 1'b0;
		end
	end

	assign pll_control = ctrl_reg;
	assign clock_output_pair_enable = drive_reg;
	assign smb_data_out = sda_out_reg;
	assign smb_data_oe_n = sda_oe_n_reg;

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_address_match_ack: assert property (byte_done && state_reg == clock_buffer_pkg::ST_ADDR
		&& shift_reg[7:1] == own_addr |=> !smb_data_oe_n && ack_reg)
		else $error("own address not acknowledged");
	a_address_miss_ignore: assert property (byte_done && state_reg == clock_buffer_pkg::ST_ADDR
		&& shift_reg[7:1] != own_addr |=> state_reg == clock_buffer_pkg::ST_IGNORE && smb_data_oe_n)
		else $error("foreign address acknowledged");
	a_read_count_first: assert property (byte_done && state_reg == clock_buffer_pkg::ST_ADDR
		&& shift_reg == {own_addr, 1'b1} |=> tx_reg == $past(regs_reg[7])
		&& state_reg == clock_buffer_pkg::ST_TX)
		else $error("read does not start with byte count");
	a_host_nak_ends: assert property (state_reg == clock_buffer_pkg::ST_TX && !ack_reg
		&& scl_rise && bitcnt_reg == 4'h8 && sda_s2_reg && !bus_start && !bus_stop
		|=> state_reg == clock_buffer_pkg::ST_IGNORE ##1 smb_data_oe_n)
		else $error("transmission continued after not-acknowledge");
	a_count_store: assert property (wr_en && wr_idx == clock_buffer_pkg::IDX_COUNT[3:0]
		|=> regs_reg[7] == $past(wr_data))
		else $error("write to count register lost");
	a_reset_values: assert property ($fell(srst) |-> regs_reg[7] == clock_buffer_pkg::COUNT_RESET
		&& regs_reg[0][7:6] == 2'b11 ##1 regs_reg[0][4] == $past(pins_s2_reg.frequency_select_pin)
		&& regs_reg[8][0] == $past(pins_s2_reg.frequency_select_pin))
		else $error("reset or latched value wrong");
	a_bypass_combine: assert property (!$past(srst) |-> ctrl_reg.zero_delay_mode
		== $past(pins_s2_reg.slave_address_strap[2] & regs_reg[2][5]))
		else $error("bypass combine wrong");
	a_bandwidth_combine: assert property (!$past(srst) |-> ctrl_reg.high_bandwidth
		== $past(~(pins_s2_reg.bandwidth_select_pin & regs_reg[2][6])))
		else $error("bandwidth combine wrong");
	a_pair_gating: assert property (!$past(srst) |-> clock_output_pair_enable[11]
		== $past(regs_reg[2][3] & ~pins_s2_reg.upper_pair_enable_pin_n)
		&& clock_output_pair_enable[0] == $past(regs_reg[1][0] & ~pins_s2_reg.output_enable_pin_n[0]))
		else $error("pair enable gating wrong");
	a_ident_load: assert property (state_reg == clock_buffer_pkg::ST_TX
		&& !ack_reg && scl_rise && bitcnt_reg == 4'h8 && !sda_s2_reg
		&& ptr_reg == clock_buffer_pkg::IDX_IDENT |=> tx_reg == {REVISION_ID, VENDOR_ID})
		else $error("identity byte wrong");
	a_pin_readback: assert property (state_reg == clock_buffer_pkg::ST_TX
		&& !ack_reg && scl_rise && bitcnt_reg == 4'h8 && !sda_s2_reg
		&& ptr_reg == clock_buffer_pkg::IDX_PIN_HIGH |=> tx_reg[4:3] == 2'b00
		&& tx_reg[2] == $past(pins_s2_reg.upper_pair_enable_pin_n))
		else $error("pin readback wrong");
	a_ack_release: assert property (ack_reg && scl_fall
		&& state_reg != clock_buffer_pkg::ST_TX |=> smb_data_oe_n && !ack_reg)
		else $error("acknowledge held past its slot");

	c_block_write: cover property (wr_en ##[1:400] wr_en);
	c_block_read: cover property (state_reg == clock_buffer_pkg::ST_TX && scl_rise
		&& bitcnt_reg == 4'h8 && !sda_s2_reg && !ack_reg);
	c_host_nak: cover property (state_reg == clock_buffer_pkg::ST_TX
		##1 state_reg == clock_buffer_pkg::ST_IGNORE);
	c_foreign_address: cover property (state_reg == clock_buffer_pkg::ST_ADDR
		##1 state_reg == clock_buffer_pkg::ST_IGNORE);
endmodule // clock_buffer_smbus_regs
`default_nettype wire

/* tb/smbus_host_model.sv */
// SMBus host model driving the bus clock and data line of the register bank
`timescale 1ns/100ps
`default_nettype none
module smbus_host_model (
	// Clock
	input wire logic clk,
	// Device side of the data line
	input wire logic smb_data_out,
	input wire logic smb_data_oe_n,
	// Bus lines
	output logic smb_clk,
	output logic smb_data
);
	logic host_sda = 1'b1;
	int naks = 0;
	initial smb_clk = 1'b1;
	// Pull-up wired with the device's open drain
	assign smb_data = smb_data_oe_n ? host_sda : smb_data_out;
	////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Data moves two clocks after the fall, clear of start and stop
	task automatic bit_x(input logic b, output logic s);
		tick(2);
		host_sda <= b;
		tick(6);
		smb_clk <= 1'b1;
		tick(6);
		s = smb_data;
		tick(2);
		smb_clk <= 1'b0;
	endtask
	task automatic start();
		tick(2);
		host_sda <= 1'b1;
		tick(6);
		smb_clk <= 1'b1;
		tick(8);
		host_sda <= 1'b0;
		tick(8);
		smb_clk <= 1'b0;
	endtask
	task automatic stop();
		tick(2);
		host_sda <= 1'b0;
		tick(6);
		smb_clk <= 1'b1;
		tick(8);
		host_sda <= 1'b1;
		tick(8);
	endtask
	// All ones in d listens; ack_in fills the ninth slot
	task automatic xfer(input logic [7:0] d, input logic ack_in,
		output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
		bit_x(ack_in, ack);
	endtask
	task automatic send(input logic [7:0] d);
		logic [7:0] q;
		logic a;
		xfer(d, 1'b1, q, a);
		if (a !== 1'b0) naks++;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic block_write(input logic [7:0] adr, idx, cnt,
		input logic [7:0] d[$]);
		start();
		send(adr);
		send(idx);
		send(cnt);
		foreach (d[i]) send(d[i]);
		stop();
	endtask
	task automatic block_read(input logic [7:0] adr, idx, input int n,
		output logic [7:0] q[$]);
		logic [7:0] b;
		logic a;
		q = {};
		start();
		send(adr);
		send(idx);
		start();
		send(adr | 8'h01);
		for (int i = 0; i <= n; i++) begin
			xfer(8'hff, i == n, b, a);
			q.push_back(b);
		end
		stop();
	endtask
endmodule // smbus_host_model
`default_nettype wire

/* tb/clock_buffer_smbus_regs_tb.sv */
// Self-checking testbench of the clock buffer SMBus register bank
`timescale 1ns/100ps
`default_nettype none
module clock_buffer_smbus_regs_tb;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic smb_clk;
	logic smb_data;
	logic smb_data_out;
	logic smb_data_oe_n;
	clock_buffer_pkg::pin_in_t pins;
	clock_buffer_pkg::pll_control_t pll_control;
	clock_buffer_pkg::pll_control_t exp_pll;
	logic [11:0] pair_en;
	int errors = 0;
	int compares = 0;
	logic [7:0] q[$];
	logic [7:0] exp_r[13];
	logic [7:0] dev = 8'hda;
	logic [7:0] b;
	logic a;
	always #4 clk = ~clk;
	clock_buffer_smbus_regs i_dut (.clk(clk), .srst(srst), .smb_clk(smb_clk),
		.smb_data_in(smb_data), .smb_data_out(smb_data_out),
		.smb_data_oe_n(smb_data_oe_n), .pins(pins), .pll_control(pll_control),
		.clock_output_pair_enable(pair_en));
	smbus_host_model i_host (.clk(clk), .smb_data_out(smb_data_out),
		.smb_data_oe_n(smb_data_oe_n), .smb_clk(smb_clk), .smb_data(smb_data));
	////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic read_all(input string name);
		i_host.block_read(dev, 8'h00, 13, q);
		check("count", 32'(q[0]), 32'(exp_r[7]));
		for (int i = 0; i < 13; i++) check(name, 32'(q[i+1]), 32'(exp_r[i]));
		$display("test %s done", name);
	endtask
	task automatic write_all(input logic [7:0] v);
		logic [7:0] d[$];
		repeat (13) d.push_back(v);
		i_host.block_write(dev, 8'h00, 8'd13, d);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		pins <= {1'b1, 1'b1, 3'b101, 1'b0, 10'h000};
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		exp_r = '{8'hfb, 8'hff, 8'hff, 8'h00, 8'he0, 8'h26, 8'h5a, 8'h09, 8'h03,
			8'h00, 8'h00, 8'h00, 8'h00};
		read_all("reset");
		exp_pll = '{1'b1, 1'b0, 1'b1, 1'b1, 5'h1b, 3'h3, 1'b0, 6'h00, 8'h00};
		check("pll", 32'(pll_control), 32'(exp_pll));
		check("pairs", 32'(pair_en), 32'hfff);
		write_all(8'h00);
		exp_r = '{8'h00, 8'h00, 8'h90, 8'h00, 8'he0, 8'h26, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h00, 8'h00};
		read_all("zeros");
		exp_pll = '{1'b0, 1'b1, 1'b0, 1'b0, 5'h00, 3'h0, 1'b0, 6'h00, 8'h00};
		check("pll", 32'(pll_control), 32'(exp_pll));
		check("pairs", 32'(pair_en), 32'h000);
		write_all(8'hff);
		exp_r = '{8'hff, 8'hff, 8'hff, 8'h00, 8'he0, 8'h26, 8'hff, 8'hff, 8'h07,
			8'h00, 8'h80, 8'h3f, 8'hff};
		read_all("ones");
		exp_pll = '{1'b1, 1'b0, 1'b1, 1'b1, 5'h1f, 3'h7, 1'b1, 6'h3f, 8'hff};
		check("pll", 32'(pll_control), 32'(exp_pll));
		pins.output_enable_pin_n <= 10'h155;
		pins.upper_pair_enable_pin_n <= 1'b1;
		pins.frequency_select_pin <= 1'b0;
		pins.bandwidth_select_pin <= 1'b0;
		repeat (8) @(posedge clk);
		check("pairs", 32'(pair_en), 32'h2aa);
		check("hbw", 32'(pll_control.high_bandwidth), 32'h1);
		exp_r[3] = 8'h55;
		exp_r[4] = 8'h25;
		read_all("pins");
		q = '{8'h11, 8'h22};
		i_host.block_write(dev, 8'h0b, 8'd1, q);
		exp_r[11] = 8'h11;
		read_all("limit");
		// Second reset with the frequency pin low: latched bits take 0
		srst <= 1'b1;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		exp_r = '{8'heb, 8'hff, 8'hff, 8'h55, 8'h25, 8'h26, 8'h5a, 8'h09, 8'h02,
			8'h00, 8'h00, 8'h00, 8'h00};
		read_all("rereset");
		exp_pll = '{1'b1, 1'b1, 1'b1, 1'b1, 5'h0b, 3'h2, 1'b0, 6'h00, 8'h00};
		check("pll", 32'(pll_control), 32'(exp_pll));
		check("pairs", 32'(pair_en), 32'h2aa);
		for (int s = 0; s < 8; s++) begin
			pins.slave_address_strap <= 3'(s);
			repeat (8) @(posedge clk);
			dev = 8'hd0 + 8'(2 * s);
			check("zdb", 32'(pll_control.zero_delay_mode), 32'(s >> 2));
			i_host.block_read(dev, 8'h05, 1, q);
			check("ident", 32'(q[1]), 32'h26);
			i_host.start();
			i_host.xfer(dev ^ 8'h02, 1'b1, b, a);
			i_host.stop();
			check("foreign", 32'(a), 32'h1);
		end
		$display("test strap done");
		check("naks", 32'(i_host.naks), 32'h0);
		conclude();
	end
	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		$display("MISMATCH watchdog expected done seen hang");
		conclude();
	end
endmodule // clock_buffer_smbus_regs_tb
`default_nettype wire
